/* File: rtl/sbcspi_regs.sv */
module sbcspi_regs #(
  parameter logic [7:0] FAMILY_ID = 8'h5A // arbitrary value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial pins
  input  wire logic       chip_select_low,
  input  wire logic       spi_clk,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  // device state
  input  wire logic [1:0] mode_now,
  input  wire logic [7:0] stat_set [sbcspi_pkg::STAT_N],
  input  wire logic [7:0] wake_level,
  // control register contents
  output logic      [7:0] ctrl_byte [sbcspi_pkg::CTRL_N]
);

  logic [2:0]  sclk_s;
  logic [2:0]  csn_s;
  logic [1:0]  sdi_s;
  logic [7:0]  lvl_s1;
  logic [7:0]  lvl_s2;
  logic [15:0] rx;
  logic [4:0]  rx_cnt;
  logic [3:0]  rise_cnt;
  logic [7:0]  tx;
  logic [7:0]  stat [sbcspi_pkg::STAT_N];
  logic [7:0]  next_stat [sbcspi_pkg::STAT_N];
  logic [7:0]  next_ctrl [sbcspi_pkg::CTRL_N];
  logic [1:0]  mode_q;
  logic [7:0]  rd_byte;
  logic [7:0]  summary;

  // edges of the synchronised pins
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_fall   = ~csn_s[1] & csn_s[2];
  wire cs_rise   = csn_s[1] & ~csn_s[2];
  wire active    = ~csn_s[1];
  wire in_restart = (mode_now == sbcspi_pkg::MODE_RESTART);
  wire mode_chg  = (mode_now != mode_q);

  // received frame fields
  wire [6:0] f_addr = rx[6:0];
  wire       f_acc  = rx[sbcspi_pkg::ACC_BIT];
  wire [7:0] f_data = rx[15:sbcspi_pkg::DATA_LSB];
  wire frame_ok = cs_rise & (rx_cnt == sbcspi_pkg::FRAME_BITS) & ~in_restart;
  wire do_write = frame_ok & f_acc & (f_addr <= sbcspi_pkg::CTRL_TOP);
  wire do_clear = frame_ok & f_acc & (f_addr >= sbcspi_pkg::STAT_BASE);

  // serial out only driven while selected
  assign serial_out_oe = active;
  assign serial_out    = tx[0];

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_s <= 3'h0;
      csn_s  <= 3'h7;
      sdi_s  <= 2'h0;
      lvl_s1 <= 8'h00;
      lvl_s2 <= 8'h00;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_clk};
      csn_s  <= {csn_s[1:0], chip_select_low};
      sdi_s  <= {sdi_s[0], serial_in};
      lvl_s1 <= wake_level;
      lvl_s2 <= lvl_s1;
    end
  end

  // receive shift on falling clock edges, count falling edges up to 31
  always_ff @(posedge clk) begin
    if (reset) begin
      rx     <= 16'h0000;
      rx_cnt <= 5'h00;
    end else if (cs_fall) begin
      rx_cnt <= 5'h00;
    end else if (active && sclk_fall) begin
      if (rx_cnt < sbcspi_pkg::FRAME_BITS) begin
        rx[rx_cnt[3:0]] <= sdi_s[1];
      end
      if (rx_cnt != sbcspi_pkg::CNT_MAX) begin
        rx_cnt <= rx_cnt + 5'h01;
      end
    end
  end

  // transmit: summary byte first, then the addressed byte
  always_ff @(posedge clk) begin
    if (reset) begin
      tx       <= 8'h00;
      rise_cnt <= 4'h0;
    end else if (cs_fall) begin
      tx       <= summary;
      rise_cnt <= 4'h0;
    end else if (active && sclk_rise) begin
      if (rise_cnt == sbcspi_pkg::DATA_RISE) begin
        tx <= rd_byte;
      end else begin
        tx <= {1'b0, tx[7:1]};
      end
      if (rise_cnt != 4'hF) begin
        rise_cnt <= rise_cnt + 4'h1;
      end
    end
  end

  // read selection from the address received so far
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < sbcspi_pkg::CTRL_N; i++) begin
      if (f_addr == sbcspi_pkg::CTRL_ADDR[i]) begin
        rd_byte = ctrl_byte[i];
      end
    end
    for (int i = 0; i < sbcspi_pkg::STAT_N; i++) begin
      if (f_addr == sbcspi_pkg::STAT_ADDR[i]) begin
        rd_byte = stat[i];
      end
    end
    if (f_addr == sbcspi_pkg::LVL_ADDR) begin
      rd_byte = lvl_s2 & sbcspi_pkg::LVL_MASK;
    end
    if (f_addr == sbcspi_pkg::ID_ADDR) begin
      rd_byte = FAMILY_ID;
    end
  end

  // summary byte, live wake level excluded
  genvar s;
  generate
    for (s = 0; s < 8; s++) begin : g_sum
      assign summary[s] = (|stat[sbcspi_pkg::SUM_A[s]]) |
                          (|stat[sbcspi_pkg::SUM_B[s]]);
    end
  endgenerate

  // status flags: set wins over a clear in the same cycle
  genvar k;
  generate
    for (k = 0; k < sbcspi_pkg::STAT_N; k++) begin : g_stat
      wire clr_hit = do_clear & (f_addr == sbcspi_pkg::STAT_ADDR[k]);
      assign next_stat[k] = (stat[k] & ~{8{clr_hit}}) |
                            (stat_set[k] & sbcspi_pkg::STAT_MASK[k]);
      always_ff @(posedge clk) begin
        if (reset) begin
          stat[k] <= sbcspi_pkg::REG_RST;
        end else begin
          stat[k] <= next_stat[k];
        end
      end
    end
  endgenerate

  // sleep entry: active transceiver field becomes wake capable
  function automatic logic [1:0] sleep_fix(input logic [1:0] v);
    sleep_fix = (v == sbcspi_pkg::BUS_OFF || v == sbcspi_pkg::BUS_WAKE) ?
                v : sbcspi_pkg::BUS_WAKE;
  endfunction : sleep_fix

  // control next values: frame write, then hardware updates on mode change
  always_comb begin
    for (int i = 0; i < sbcspi_pkg::CTRL_N; i++) begin
      next_ctrl[i] = ctrl_byte[i];
      if (do_write && f_addr == sbcspi_pkg::CTRL_ADDR[i]) begin
        next_ctrl[i] = f_data & sbcspi_pkg::CTRL_MASK[i];
      end
    end
    if (mode_chg) begin
      next_ctrl[sbcspi_pkg::IX_MODE][sbcspi_pkg::MODE_LSB +: 2] = mode_now;
      // stop keeps transceiver fields; switches stay on in stop and sleep
      if (mode_now == sbcspi_pkg::MODE_SLEEP) begin
        next_ctrl[sbcspi_pkg::IX_BUS_A][sbcspi_pkg::CAN_LSB +: 2] =
          sleep_fix(ctrl_byte[sbcspi_pkg::IX_BUS_A][sbcspi_pkg::CAN_LSB +: 2]);
        next_ctrl[sbcspi_pkg::IX_BUS_A][sbcspi_pkg::LIN1_LSB +: 2] =
          sleep_fix(ctrl_byte[sbcspi_pkg::IX_BUS_A][sbcspi_pkg::LIN1_LSB +: 2]);
        next_ctrl[sbcspi_pkg::IX_BUS_B][sbcspi_pkg::LIN2_LSB +: 2] =
          sleep_fix(ctrl_byte[sbcspi_pkg::IX_BUS_B][sbcspi_pkg::LIN2_LSB +: 2]);
      end
      if (mode_now == sbcspi_pkg::MODE_RESTART) begin
        next_ctrl[sbcspi_pkg::IX_HS_A] = 8'h00;
        next_ctrl[sbcspi_pkg::IX_HS_B] = 8'h00;
        next_ctrl[sbcspi_pkg::IX_MODE] = next_ctrl[sbcspi_pkg::IX_MODE] &
                                         ~sbcspi_pkg::SECOND_REGULATOR_BITS;
      end
    end
  end

  // control registers and mode tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= sbcspi_pkg::MODE_NORMAL;
      for (int i = 0; i < sbcspi_pkg::CTRL_N; i++) begin
        ctrl_byte[i] <= sbcspi_pkg::REG_RST;
      end
    end else begin
      mode_q <= mode_now;
      ctrl_byte <= next_ctrl;
    end
  end

  // checks on the register behaviour
  write_apply_a: assert property (@(posedge clk) disable iff (reset)
    do_write && f_addr == sbcspi_pkg::CTRL_ADDR[sbcspi_pkg::IX_HS_A] && !mode_chg
    |=> ctrl_byte[sbcspi_pkg::IX_HS_A] ==
        ($past(f_data) & sbcspi_pkg::CTRL_MASK[sbcspi_pkg::IX_HS_A]))
    else $error("control write not applied");

  read_only_a: assert property (@(posedge clk) disable iff (reset)
    cs_rise && !f_acc && !mode_chg
    |=> ctrl_byte[sbcspi_pkg::IX_HS_A] == $past(ctrl_byte[sbcspi_pkg::IX_HS_A]))
    else $error("read frame changed a control register");

  restart_ignore_a: assert property (@(posedge clk) disable iff (reset)
    cs_rise && in_restart && !mode_chg
    |=> ctrl_byte[sbcspi_pkg::CTRL_N-1] == $past(ctrl_byte[sbcspi_pkg::CTRL_N-1]))
    else $error("frame acted during restart");

  bad_count_a: assert property (@(posedge clk) disable iff (reset)
    cs_rise && rx_cnt != sbcspi_pkg::FRAME_BITS && !mode_chg
    |=> ctrl_byte[sbcspi_pkg::CTRL_N-1] == $past(ctrl_byte[sbcspi_pkg::CTRL_N-1]))
    else $error("frame with wrong clock count acted");

  stat_clear_a: assert property (@(posedge clk) disable iff (reset)
    do_clear && f_addr == sbcspi_pkg::STAT_ADDR[0] && stat_set[0] == 8'h00
    |=> stat[0] == 8'h00)
    else $error("status clear failed");

  flag_sticky_a: assert property (@(posedge clk) disable iff (reset)
    !do_clear |=> (stat[1] & $past(stat[1])) == $past(stat[1]))
    else $error("status flag dropped without clear");

  bus_summary_a: assert property (@(posedge clk) disable iff (reset)
    summary[3] == ((|stat[4]) || (|stat[5])))
    else $error("bus summary bit wrong");

  wake_summary_a: assert property (@(posedge clk) disable iff (reset)
    summary[4] == ((|stat[6]) || (|stat[7])))
    else $error("wake summary bit wrong");

  summary_out_a: assert property (@(posedge clk) disable iff (reset)
    cs_fall |=> serial_out == $past(summary[0]) && serial_out_oe)
    else $error("summary bit 0 not presented");

  data_out_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_rise && rise_cnt == sbcspi_pkg::DATA_RISE
    |=> serial_out == $past(rd_byte[0]))
    else $error("data byte not presented");

  release_out_a: assert property (@(posedge clk) disable iff (reset)
    cs_rise |-> !serial_out_oe ##1 !serial_out_oe)
    else $error("serial out driven after deselect");

  mode_field_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg |=> ctrl_byte[sbcspi_pkg::IX_MODE][7:6] == $past(mode_now))
    else $error("mode field not updated");

  sleep_field_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg && mode_now == sbcspi_pkg::MODE_SLEEP &&
    ctrl_byte[sbcspi_pkg::IX_BUS_A][1:0] > sbcspi_pkg::BUS_WAKE
    |=> ctrl_byte[sbcspi_pkg::IX_BUS_A][1:0] == sbcspi_pkg::BUS_WAKE)
    else $error("transceiver field not made wake capable");

  restart_clear_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg && in_restart
    |=> ctrl_byte[sbcspi_pkg::IX_HS_A] == 8'h00 &&
        (ctrl_byte[sbcspi_pkg::IX_MODE] & sbcspi_pkg::SECOND_REGULATOR_BITS) == 8'h00)
    else $error("high side bits not cleared in restart");

  rx_restart_a: assert property (@(posedge clk) disable iff (reset)
    cs_fall |=> rx_cnt == 5'h00)
    else $error("clock count not restarted at select");

  rx_sample_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_fall && !cs_fall && rx_cnt < sbcspi_pkg::FRAME_BITS
    |=> rx[$past(rx_cnt[3:0])] == $past(sdi_s[1]))
    else $error("serial input bit not sampled");

  tx_shift_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_rise && !cs_fall && rise_cnt != sbcspi_pkg::DATA_RISE
    |=> serial_out == $past(tx[1]))
    else $error("serial output not shifted");

  flag_set_a: assert property (@(posedge clk) disable iff (reset)
    stat_set[2] != 8'h00
    |=> (stat[2] & $past(stat_set[2]) & sbcspi_pkg::STAT_MASK[2]) ==
        ($past(stat_set[2]) & sbcspi_pkg::STAT_MASK[2]))
    else $error("status flag not set");

  last_clear_a: assert property (@(posedge clk) disable iff (reset)
    do_clear && f_addr == sbcspi_pkg::STAT_ADDR[9] && stat_set[9] == 8'h00
    |=> stat[9] == 8'h00)
    else $error("open load status clear failed");

  summary_low_a: assert property (@(posedge clk) disable iff (reset)
    stat[1] == 8'h00 |-> !summary[0])
    else $error("summary bit set with clear register");

  summary_high_a: assert property (@(posedge clk) disable iff (reset)
    stat[8] != 8'h00 |-> summary[6])
    else $error("overload summary bit not set");

  stop_keep_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg && mode_now == sbcspi_pkg::MODE_STOP && !do_write
    |=> ctrl_byte[sbcspi_pkg::IX_BUS_A] == $past(ctrl_byte[sbcspi_pkg::IX_BUS_A]) &&
        ctrl_byte[sbcspi_pkg::IX_BUS_B] == $past(ctrl_byte[sbcspi_pkg::IX_BUS_B]))
    else $error("transceiver fields changed on stop entry");

  switch_keep_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg && !in_restart && !do_write
    |=> ctrl_byte[sbcspi_pkg::IX_HS_A] == $past(ctrl_byte[sbcspi_pkg::IX_HS_A]))
    else $error("high side switch changed on low power entry");

  lin_sleep_a: assert property (@(posedge clk) disable iff (reset)
    mode_chg && mode_now == sbcspi_pkg::MODE_SLEEP &&
    ctrl_byte[sbcspi_pkg::IX_BUS_B][sbcspi_pkg::LIN2_LSB +: 2] > sbcspi_pkg::BUS_WAKE
    |=> ctrl_byte[sbcspi_pkg::IX_BUS_B][sbcspi_pkg::LIN2_LSB +: 2] == sbcspi_pkg::BUS_WAKE)
    else $error("second line field not made wake capable");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (reset)
    !frame_ok && !mode_chg
    |=> ctrl_byte[sbcspi_pkg::IX_BUS_B] == $past(ctrl_byte[sbcspi_pkg::IX_BUS_B]))
    else $error("control register changed outside a frame end");

  unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_rise && !cs_fall && rise_cnt == sbcspi_pkg::DATA_RISE &&
    f_addr == 7'h7F
    |=> !serial_out)
    else $error("unassigned address read not zero");

  id_read_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_rise && !cs_fall && rise_cnt == sbcspi_pkg::DATA_RISE &&
    f_addr == sbcspi_pkg::ID_ADDR
    |=> serial_out == FAMILY_ID[0])
    else $error("identification byte not presented");

  level_read_a: assert property (@(posedge clk) disable iff (reset)
    active && sclk_rise && !cs_fall && rise_cnt == sbcspi_pkg::DATA_RISE &&
    f_addr == sbcspi_pkg::LVL_ADDR
    |=> serial_out == $past(lvl_s2[0]))
    else $error("wake level byte not presented");

endmodule : sbcspi_regs

/* File: common/sbcspi_pkg.sv */
// How it works
// - frame: address bits 6..0, access bit 7, data bits 15..8
// - access bit picks read or read-clear for status, read or write for control
// - each frame reads, writes or clears one byte of one register
// - status flags stay set until the host clears them
// - frames ending in restart mode are not interpreted
// - status register contents return in the same frame
// - control register byte returns in the same frame
// - written value shows only from the next frame on
// - every response carries an eight-bit status summary byte
// - summary bit sets once any flag of its register is set
// - summary bit drops only when all its flags are cleared
// - summary map: 41,42,43,bus,wake,40,54,55 on bits 0..7
// - summary bit 3 is the OR of both bus failure registers
// - summary bit 4 is the OR of both wake source registers
// - live wake level register feeds no summary bit
// - addresses 00..1E are control: access 0 reads, 1 writes
// - addresses 40..7E are status: access 1 clears, 0 reads
// - wake level and identification registers ignore clears
// - any mode change updates the mode field to the real mode
// - stop or sleep keep diagnosis flags and fail outputs
// - stop leaves transceiver control fields unchanged
// - sleep turns active transceiver fields into wake capable
// - switches and regulators stay on in stop and sleep
// - restart clears high side and stand-alone regulator bits
// - frame acts at chip select rise, serial out goes high-z
// - sample on falling clock edge, shift out after rising edge
// - frames with a clock count other than 16 are dropped, a count of 0 included
package sbcspi_pkg;
  localparam int CTRL_N = 19;
  localparam int STAT_N = 10;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [3:0] DATA_RISE = 4'h7;
  localparam int ACC_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam logic [6:0] CTRL_TOP = 7'h1E;
  localparam logic [6:0] STAT_BASE = 7'h40;
  localparam logic [6:0] LVL_ADDR = 7'h48;
  localparam logic [6:0] ID_ADDR = 7'h7E;
  localparam logic [7:0] LVL_MASK = 8'hF7;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] CTRL_ADDR [CTRL_N] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0C,
    7'h0D, 7'h10, 7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E};
  localparam logic [7:0] CTRL_MASK [CTRL_N] = '{
    8'hFF, 8'hFB, 8'hF7, 8'hFB, 8'h23, 8'hC4, 8'hA7, 8'h3F, 8'h3F, 8'h77,
    8'h77, 8'h70, 8'h77, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'hFF};
  localparam logic [6:0] STAT_ADDR [STAT_N] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam logic [7:0] STAT_MASK [STAT_N] = '{
    8'h5F, 8'hFF, 8'h07, 8'hCF, 8'h67, 8'h06, 8'hF7, 8'h30, 8'h0F, 8'h0F};
  // summary bit i is status index SUM_A[i] or SUM_B[i]
  localparam int SUM_A [8] = '{1, 2, 3, 4, 6, 0, 8, 9};
  localparam int SUM_B [8] = '{1, 2, 3, 5, 7, 0, 8, 9};
  localparam int IX_MODE = 0;
  localparam int IX_BUS_A = 3;
  localparam int IX_BUS_B = 4;
  localparam int IX_HS_A = 12;
  localparam int IX_HS_B = 13;
  localparam int MODE_LSB = 6;
  localparam int CAN_LSB = 0;
  localparam int LIN1_LSB = 3;
  localparam int LIN2_LSB = 0;
  localparam logic [7:0] SECOND_REGULATOR_BITS = 8'h18;
  localparam logic [1:0] BUS_OFF = 2'h0;
  localparam logic [1:0] BUS_WAKE = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_RESTART = 2'h3;
endpackage : sbcspi_pkg

/* File: tb/sbcspi_host.sv */
module sbcspi_host (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      chip_select_low,
  output logic      spi_clk,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: select high, clock low
  initial begin
    chip_select_low = 1'b1;
    spi_clk = 1'b0;
    serial_in = 1'b0;
  end

  // one frame of nb clocks, lsb first, half period of four system clocks
  task automatic xfer(input int nb, input logic [15:0] w,
                      output logic [15:0] r, output logic oe);
    r = 16'h0000;
    oe = 1'b1;
    @(posedge clk);
    chip_select_low <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      @(negedge clk);
      if (i < 16) r[i] = serial_out;
      oe = oe & serial_out_oe;
      @(posedge clk);
      spi_clk <= 1'b1;
      serial_in <= w[i % 16];
      repeat (4) @(posedge clk);
      spi_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    chip_select_low <= 1'b1;
    // released line shows the inverse of the last bit
    serial_in <= ~serial_in;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : sbcspi_host

/* File: tb/sbcspi_regs_tb_top.sv */
module sbcspi_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID = 8'hA3; // arbitrary value
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic chip_select_low, spi_clk, serial_in, serial_out, serial_out_oe;
  logic [1:0] mode_now = 2'h0;
  logic [7:0] wake_level = 8'h00;
  logic [7:0] stat_set [sbcspi_pkg::STAT_N] = '{default: 8'h00};
  logic [7:0] ctrl_byte [sbcspi_pkg::CTRL_N];
  logic [7:0] m_ctrl [sbcspi_pkg::CTRL_N] = '{default: 8'h00};
  logic [7:0] m_stat [sbcspi_pkg::STAT_N] = '{default: 8'h00};
  int n_errors = 0;
  int n_compared = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  // design and host
  sbcspi_regs #(.FAMILY_ID(ID)) u_sbcspi_regs (.clk(clk), .reset(reset),
    .chip_select_low(chip_select_low), .spi_clk(spi_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .mode_now(mode_now),
    .stat_set(stat_set), .wake_level(wake_level), .ctrl_byte(ctrl_byte));
  sbcspi_host u_sbcspi_host (.clk(clk), .chip_select_low(chip_select_low),
    .spi_clk(spi_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // model lookups by address
  function automatic int cix(input logic [6:0] a);
    for (int i = 0; i < sbcspi_pkg::CTRL_N; i++)
      if (sbcspi_pkg::CTRL_ADDR[i] == a) return i;
    return -1;
  endfunction : cix

  function automatic int six(input logic [6:0] a);
    for (int i = 0; i < sbcspi_pkg::STAT_N; i++)
      if (sbcspi_pkg::STAT_ADDR[i] == a) return i;
    return -1;
  endfunction : six

  function automatic logic [7:0] summ();
    for (int b = 0; b < 8; b++)
      summ[b] = (m_stat[sbcspi_pkg::SUM_A[b]] | m_stat[sbcspi_pkg::SUM_B[b]]) != 8'h00;
  endfunction : summ

  function automatic logic [7:0] mread(input logic [6:0] a);
    if (cix(a) >= 0) return m_ctrl[cix(a)];
    if (six(a) >= 0) return m_stat[six(a)];
    if (a == sbcspi_pkg::LVL_ADDR) return wake_level & sbcspi_pkg::LVL_MASK;
    if (a == sbcspi_pkg::ID_ADDR) return ID;
    return 8'h00;
  endfunction : mread

  task automatic cmpall();
    for (int i = 0; i < sbcspi_pkg::CTRL_N; i++)
      check(ctrl_byte[i], m_ctrl[i]);
  endtask : cmpall

  // one frame, checked against the model, then the model takes its effect
  task automatic frame(input int nb, input logic acc, input logic [6:0] a,
                       input logic [7:0] d);
    logic [15:0] r;
    logic oe;
    logic [7:0] s;
    logic [7:0] e;
    s = summ();
    e = mread(a);
    u_sbcspi_host.xfer(nb, {d, acc, a}, r, oe);
    @(negedge clk);
    if (nb == 16 && mode_now != sbcspi_pkg::MODE_RESTART) begin
      check(r[7:0], s);
      check(r[15:8], e);
      check({7'h00, oe}, 8'h01);
      if (acc && cix(a) >= 0) m_ctrl[cix(a)] = d & sbcspi_pkg::CTRL_MASK[cix(a)];
      if (acc && six(a) >= 0) m_stat[six(a)] = 8'h00;
    end
    check({7'h00, serial_out_oe}, 8'h00);
    cmpall();
  endtask : frame

  task automatic setf(input int i, input logic [7:0] v);
    @(posedge clk);
    stat_set[i] <= v;
    @(posedge clk);
    stat_set[i] <= 8'h00;
    m_stat[i] = m_stat[i] | (v & sbcspi_pkg::STAT_MASK[i]);
    @(negedge clk);
  endtask : setf

  task automatic mode(input logic [1:0] m);
    int ix;
    int lb;
    @(posedge clk);
    mode_now <= m;
    repeat (3) @(posedge clk);
    @(negedge clk);
    m_ctrl[sbcspi_pkg::IX_MODE][7:6] = m;
    for (int k = 0; k < 3; k++) begin
      ix = (k == 2) ? sbcspi_pkg::IX_BUS_B : sbcspi_pkg::IX_BUS_A;
      lb = (k == 1) ? sbcspi_pkg::LIN1_LSB : (k == 2) ? sbcspi_pkg::LIN2_LSB : 0;
      if (m == sbcspi_pkg::MODE_SLEEP && m_ctrl[ix][lb+:2] > sbcspi_pkg::BUS_WAKE)
        m_ctrl[ix][lb+:2] = sbcspi_pkg::BUS_WAKE;
    end
    if (m == sbcspi_pkg::MODE_RESTART) begin
      m_ctrl[sbcspi_pkg::IX_HS_A] = 8'h00;
      m_ctrl[sbcspi_pkg::IX_HS_B] = 8'h00;
      m_ctrl[sbcspi_pkg::IX_MODE] &= ~sbcspi_pkg::SECOND_REGULATOR_BITS;
    end
    cmpall();
  endtask : mode

  // cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(68574));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    wake_level <= 8'($urandom);
    repeat (4) @(posedge clk);
    for (int i = 0; i < sbcspi_pkg::CTRL_N; i++) begin
      frame(16, 1'b1, sbcspi_pkg::CTRL_ADDR[i], 8'($urandom));
      frame(16, 1'b0, sbcspi_pkg::CTRL_ADDR[i], 8'($urandom));
    end
    $display("test control done");
    for (int i = 0; i < sbcspi_pkg::STAT_N; i++) begin
      setf(i, 8'($urandom));
      if (m_stat[i] == 8'h00) setf(i, sbcspi_pkg::STAT_MASK[i]);
      frame(16, 1'b0, sbcspi_pkg::STAT_ADDR[i], 8'($urandom));
    end
    for (int i = 0; i < sbcspi_pkg::STAT_N; i++)
      frame(16, 1'b1, sbcspi_pkg::STAT_ADDR[i], 8'($urandom));
    for (int i = 0; i < 2; i++) begin
      frame(16, 1'b1, sbcspi_pkg::LVL_ADDR, 8'hFF);
      frame(16, 1'b1, sbcspi_pkg::ID_ADDR, 8'hFF);
      frame(16, 1'b1, 7'h00, 8'hFF);
      frame(16, 1'b0, 7'h7F, 8'h00);
    end
    $display("test status done");
    frame(0, 1'b1, 7'h1E, 8'hA5);
    frame(15, 1'b1, 7'h1E, 8'hA5);
    frame(17, 1'b1, 7'h1E, 8'hA5);
    $display("test counts done");
    setf(8, 8'h0F);
    frame(16, 1'b1, 7'h04, 8'h1A);
    frame(16, 1'b1, 7'h05, 8'h02);
    frame(16, 1'b1, 7'h14, 8'($urandom));
    mode(sbcspi_pkg::MODE_STOP);
    mode(sbcspi_pkg::MODE_NORMAL);
    mode(sbcspi_pkg::MODE_SLEEP);
    frame(16, 1'b0, 7'h54, 8'h00);
    mode(sbcspi_pkg::MODE_RESTART);
    frame(16, 1'b1, 7'h1E, 8'hFF);
    mode(sbcspi_pkg::MODE_NORMAL);
    $display("test modes done");
    final_report();
  end
endmodule : sbcspi_regs_tb_top
